// ==== core/cpf_pkg.sv ====
// shared constants, types and layouts of the codec port queue datapath
package cpf_pkg;
	localparam int unsigned CPF_DEPTH = 16;
	localparam int unsigned CPF_WIDTH = 32;
	localparam logic [4:0] CPF_DEPTH_LV = 5'h10;
	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [4:0] CPF_OFS_CONFIG = 5'h00;
	localparam logic [4:0] CPF_OFS_THRESH = 5'h04;
	localparam logic [4:0] CPF_OFS_LINE = 5'h08;
	localparam logic [4:0] CPF_OFS_LEVEL = 5'h0C;
	localparam logic [4:0] CPF_OFS_LINES = 5'h10;
	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int unsigned CPF_POS_IN_THR = 0;
	localparam int unsigned CPF_POS_OUT_THR = 8;
	localparam int unsigned CPF_POS_LINE_POS = 16;
	localparam int unsigned CPF_POS_LV_STEP = 8;
	////////////////////////////////////////////////////////////////////////
	// values after reset, and the largest line length
	localparam logic [2:0] CPF_RST_DSC = 3'h2;
	localparam logic [4:0] CPF_RST_IN_THR = 5'h04;
	localparam logic [4:0] CPF_RST_OUT_THR = 5'h04;
	localparam logic [11:0] CPF_RST_LINE = 12'h800;
	localparam logic [11:0] CPF_MAX_LINE = 12'h800;
	////////////////////////////////////////////////////////////////////////
	// bytes per queue entry
	localparam logic [2:0] CPF_BYTES_WORD = 3'h4;
	localparam logic [2:0] CPF_BYTES_HALF = 3'h2;
	localparam logic [2:0] CPF_BYTES_PIX = 3'h1;
	////////////////////////////////////////////////////////////////////////
	// queue index on the grant pins
	localparam int unsigned CPF_Q_RAW_IN = 0;
	localparam int unsigned CPF_Q_PACKED_OUT = 1;
	localparam int unsigned CPF_Q_PACKED_IN = 2;
	localparam int unsigned CPF_Q_RAW_OUT = 3;
	////////////////////////////////////////////////////////////////////////
	// configuration word, bus16 at bit 0, strobe condition at bits 10:8
	typedef struct packed {
		logic [2:0] dsc;
		logic spare;
		logic pix_out;
		logic pix_in;
		logic pass;
		logic bitrev;
		logic dswap;
		logic cswap;
		logic bus16;
	} cpf_cfg_s;
	localparam int unsigned CPF_CFG_W = 11;
	typedef enum logic [0:0] {
		CPF_BUS_WAIT = 1'b0,
		CPF_BUS_ACK = 1'b1
	} cpf_bus_e;
endpackage

// ==== core/cpf_queue.sv ====
// one 16 x 32 queue with a registered head word
`timescale 1ns/10ps
module cpf_queue (
	input logic clk,
	input logic rst_n,
	input logic push,
	input logic [31:0] din,
	output logic full,
	input logic pop,
	output logic [31:0] dout,
	output logic valid,
	output logic [4:0] level
);
	import cpf_pkg::*;
	logic [31:0] mem [CPF_DEPTH];
	logic [3:0] wp_reg;
	logic [3:0] rp_reg;
	logic [4:0] cnt_reg;
	logic [31:0] head_reg;
	logic head_vld_reg;
	logic push_ok;
	logic load;
	////////////////////////////////////////////////////////////////////////
	assign full = cnt_reg == CPF_DEPTH_LV;
	assign push_ok = push & ~full;
	assign load = (cnt_reg != 5'h00) & (~head_vld_reg | pop);
	assign dout = head_reg;
	assign valid = head_vld_reg;
	assign level = cnt_reg + {4'h0, head_vld_reg};
	always_ff @(posedge clk) begin
		if (push_ok) begin
			mem[wp_reg] <= din;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg <= 4'h0;
			rp_reg <= 4'h0;
			cnt_reg <= 5'h00;
		end else begin
			if (push_ok) begin
				wp_reg <= wp_reg + 4'h1;
			end
			if (load) begin
				rp_reg <= rp_reg + 4'h1;
			end
			cnt_reg <= cnt_reg + {4'h0, push_ok} - {4'h0, load};
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			head_reg <= 32'h0000_0000;
			head_vld_reg <= 1'b0;
		end else begin
			if (load) begin
				head_reg <= mem[rp_reg];
			end
			head_vld_reg <= load | (head_vld_reg & ~pop);
		end
	end
endmodule

// ==== core/cpf_byte_engine.sv ====
// byte-per-clock engine: unpacks queue words, packs output words
`timescale 1ns/10ps
module cpf_byte_engine (
	input logic clk,
	input logic rst_n,
	input logic in_valid,
	input logic [31:0] in_data,
	input logic [2:0] in_bytes,
	output logic in_pop,
	input logic bitrev,
	input logic [2:0] out_bytes,
	input logic out_ready,
	output logic out_valid,
	output logic [31:0] out_data,
	output logic byte_step
);
	import cpf_pkg::*;
	logic [1:0] idx_reg;
	logic [1:0] cnt_reg;
	logic [31:0] acc_reg;
	logic [31:0] word_reg;
	logic pend_reg;
	logic [7:0] cur;
	logic [31:0] acc_next;
	logic last_in;
	logic last_out;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction
	////////////////////////////////////////////////////////////////////////
	assign byte_step = in_valid & (~pend_reg | out_ready);
	assign last_in = ({1'b0, idx_reg} + 3'h1) == in_bytes;
	assign last_out = ({1'b0, cnt_reg} + 3'h1) == out_bytes;
	assign in_pop = byte_step & last_in;
	assign cur = bitrev ? rev8(in_data[idx_reg*8 +: 8]) : in_data[idx_reg*8 +: 8];
	assign out_valid = pend_reg;
	assign out_data = word_reg;
	always_comb begin
		acc_next = acc_reg;
		acc_next[cnt_reg*8 +: 8] = cur;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_reg <= 2'h0;
		end else if (byte_step) begin
			idx_reg <= last_in ? 2'h0 : idx_reg + 2'h1;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 2'h0;
			acc_reg <= 32'h0000_0000;
			word_reg <= 32'h0000_0000;
		end else if (byte_step) begin
			cnt_reg <= last_out ? 2'h0 : cnt_reg + 2'h1;
			acc_reg <= last_out ? 32'h0000_0000 : acc_next;
			if (last_out) begin
				word_reg <= acc_next;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= 1'b0;
		end else if (byte_step & last_out) begin
			pend_reg <= 1'b1;
		end else if (out_ready) begin
			pend_reg <= 1'b0;
		end
	end
endmodule

// ==== core/cpf_datapath.sv ====
// codec port queue datapath: four queues, two byte engines, ports
`timescale 1ns/10ps
module cpf_datapath (
	input logic REF_CLK,
	input logic NRST,
	input logic [4:0] AVS_ADDRESS,
	input logic AVS_READ,
	input logic AVS_WRITE,
	input logic [31:0] AVS_WRITEDATA,
	input logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input logic [31:0] DATA_IN,
	output logic [31:0] DATA_OUT,
	output logic DATA_OE,
	input logic STROBE_QUAL,
	input logic [3:0] TRANSFER_GRANT_N,
	output logic RAW_IN_REQUEST_N,
	output logic PACKED_OUT_REQUEST_N,
	output logic PACKED_IN_REQUEST_N,
	output logic RAW_OUT_REQUEST_N,
	input logic [7:0] PIXEL_BYTE_INPUT,
	output logic PIXEL_IN_PORT_REQUEST_N,
	input logic PIXEL_IN_PORT_GRANT_N,
	output logic [7:0] PIXEL_BYTE_OUTPUT,
	output logic PIXEL_OUT_PORT_REQUEST_N,
	input logic PIXEL_OUT_PORT_GRANT_N
);
	import cpf_pkg::*;
	////////////////////////////////////////////////////////////////////////
	// declarations
	cpf_bus_e bus_reg;
	cpf_cfg_s cfg_reg;
	logic [4:0] in_thr_reg;
	logic [4:0] out_thr_reg;
	logic [11:0] line_len_reg;
	logic [11:0] line_pos_reg;
	logic [15:0] lines_reg;
	logic [31:0] rdata_reg;
	logic [3:0] grant_d_reg;
	logic sd_d_reg;
	logic [31:0] din_d_reg;
	logic [3:0] strobe;
	logic [31:0] bus_word;
	logic bus_req;
	logic wr_take;
	logic [31:0] rd_mux;
	logic [2:0] port_bytes;
	logic [31:0] q_din [4];
	logic [31:0] q_dout [4];
	logic [3:0] q_push;
	logic [3:0] q_pop;
	logic [3:0] q_full;
	logic [3:0] q_valid;
	logic [4:0] q_level [4];
	logic ce_pop;
	logic ce_step;
	logic ce_valid;
	logic [31:0] ce_word;
	logic de_pop;
	logic de_valid;
	logic [31:0] de_word;
	logic pix_in_req;
	logic pix_out_req;
	logic line_end;
	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] order(input logic [31:0] w, input logic half,
			input logic en);
		logic [31:0] r;
		r = w;
		if (en & half) begin
			r = {16'h0000, w[7:0], w[15:8]};
		end else if (en) begin
			r = {w[7:0], w[15:8], w[23:16], w[31:24]};
		end
		return r;
	endfunction
	function automatic logic strobe_hit(input logic [2:0] dsc, input logic a_n,
			input logic ad_n, input logic sd, input logic sdd);
		logic hit;
		unique case (dsc)
			3'h0: hit = ~a_n & ~ad_n & sd;
			3'h1: hit = ~a_n & ~ad_n & ~sd;
			3'h2: hit = ~a_n & sd;
			3'h3: hit = ~a_n & ~sd;
			3'h4: hit = ~ad_n & sdd;
			3'h5: hit = ~ad_n & ~sdd;
			3'h6: hit = a_n & ~ad_n;
			3'h7: hit = a_n & ~ad_n;
		endcase
		return hit;
	endfunction
	function automatic logic [4:0] space(input logic [4:0] lv);
		return (lv >= CPF_DEPTH_LV) ? 5'h00 : CPF_DEPTH_LV - lv;
	endfunction
	function automatic logic [31:0] be_merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction
	////////////////////////////////////////////////////////////////////////
	// register bus slave: one wait cycle, then the answer
	assign bus_req = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = bus_req & (bus_reg == CPF_BUS_WAIT);
	assign wr_take = AVS_WRITE & (bus_reg == CPF_BUS_ACK);
	assign AVS_READDATA = rdata_reg;
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			bus_reg <= CPF_BUS_WAIT;
		end else begin
			unique case (bus_reg)
				CPF_BUS_WAIT: bus_reg <= bus_req ? CPF_BUS_ACK : CPF_BUS_WAIT;
				CPF_BUS_ACK: bus_reg <= CPF_BUS_WAIT;
			endcase
		end
	end
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (AVS_ADDRESS)
			CPF_OFS_CONFIG: rd_mux = {21'h0, cfg_reg};
			CPF_OFS_THRESH: begin
				rd_mux[CPF_POS_IN_THR +: 5] = in_thr_reg;
				rd_mux[CPF_POS_OUT_THR +: 5] = out_thr_reg;
			end
			CPF_OFS_LINE: begin
				rd_mux[11:0] = line_len_reg;
				rd_mux[CPF_POS_LINE_POS +: 12] = line_pos_reg;
			end
			CPF_OFS_LEVEL: begin
				for (int i = 0; i < 4; i++) begin
					rd_mux[i*CPF_POS_LV_STEP +: 5] = q_level[i];
				end
			end
			CPF_OFS_LINES: rd_mux = {16'h0000, lines_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rdata_reg <= 32'h0000_0000;
		end else if (AVS_READ & (bus_reg == CPF_BUS_WAIT)) begin
			rdata_reg <= rd_mux;
		end
	end
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			cfg_reg <= '{dsc: CPF_RST_DSC, default: 1'b0};
		end else if (wr_take & (AVS_ADDRESS == CPF_OFS_CONFIG)) begin
			cfg_reg <= cpf_cfg_s'(CPF_CFG_W'(be_merge({21'h0, cfg_reg}, AVS_WRITEDATA,
				AVS_BYTEENABLE)));
		end
	end
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			in_thr_reg <= CPF_RST_IN_THR;
			out_thr_reg <= CPF_RST_OUT_THR;
		end else if (wr_take & (AVS_ADDRESS == CPF_OFS_THRESH)) begin
			if (AVS_BYTEENABLE[0]) begin
				in_thr_reg <= AVS_WRITEDATA[CPF_POS_IN_THR +: 5];
			end
			if (AVS_BYTEENABLE[1]) begin
				out_thr_reg <= AVS_WRITEDATA[CPF_POS_OUT_THR +: 5];
			end
		end
	end
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			line_len_reg <= CPF_RST_LINE;
		end else if (wr_take & (AVS_ADDRESS == CPF_OFS_LINE) & AVS_BYTEENABLE[0]
				& AVS_BYTEENABLE[1]) begin
			if (AVS_WRITEDATA[11:0] > CPF_MAX_LINE) begin
				line_len_reg <= CPF_MAX_LINE;
			end else begin
				line_len_reg <= AVS_WRITEDATA[11:0];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// data port strobe condition, one per queue
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			grant_d_reg <= 4'hF;
			sd_d_reg <= 1'b0;
			din_d_reg <= 32'h0000_0000;
		end else begin
			grant_d_reg <= TRANSFER_GRANT_N;
			sd_d_reg <= STROBE_QUAL;
			din_d_reg <= DATA_IN;
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			strobe[i] = strobe_hit(cfg_reg.dsc, TRANSFER_GRANT_N[i], grant_d_reg[i],
				STROBE_QUAL, sd_d_reg);
		end
	end
	// delayed conditions take the word seen one edge earlier
	assign bus_word = cfg_reg.dsc[2] ? din_d_reg : DATA_IN;
	assign port_bytes = cfg_reg.bus16 ? CPF_BYTES_HALF : CPF_BYTES_WORD;
	////////////////////////////////////////////////////////////////////////
	// queue inputs and outputs
	assign pix_in_req = cfg_reg.pix_in & ~q_full[CPF_Q_RAW_IN];
	assign PIXEL_IN_PORT_REQUEST_N = ~pix_in_req;
	assign pix_out_req = cfg_reg.pix_out & q_valid[CPF_Q_RAW_OUT];
	assign PIXEL_OUT_PORT_REQUEST_N = ~pix_out_req;
	assign PIXEL_BYTE_OUTPUT = q_dout[CPF_Q_RAW_OUT][7:0];
	always_comb begin
		q_push[CPF_Q_RAW_IN] = cfg_reg.pix_in ? pix_in_req & ~PIXEL_IN_PORT_GRANT_N
			: strobe[CPF_Q_RAW_IN];
		q_din[CPF_Q_RAW_IN] = cfg_reg.pix_in ? {24'h000000, PIXEL_BYTE_INPUT}
			: order(cfg_reg.bus16 ? {16'h0000, bus_word[15:0]} : bus_word,
			cfg_reg.bus16, cfg_reg.cswap & ~cfg_reg.pass);
		q_push[CPF_Q_PACKED_IN] = strobe[CPF_Q_PACKED_IN];
		q_din[CPF_Q_PACKED_IN] = cfg_reg.bus16 ? {16'h0000, bus_word[15:0]} : bus_word;
		q_push[CPF_Q_PACKED_OUT] = ce_valid;
		q_din[CPF_Q_PACKED_OUT] = ce_word;
		q_push[CPF_Q_RAW_OUT] = de_valid;
		q_din[CPF_Q_RAW_OUT] = cfg_reg.pix_out ? de_word
			: order(de_word, cfg_reg.bus16, cfg_reg.dswap & ~cfg_reg.pass);
	end
	always_comb begin
		q_pop[CPF_Q_RAW_IN] = ce_pop;
		q_pop[CPF_Q_PACKED_IN] = de_pop;
		q_pop[CPF_Q_PACKED_OUT] = strobe[CPF_Q_PACKED_OUT]
			& q_valid[CPF_Q_PACKED_OUT];
		q_pop[CPF_Q_RAW_OUT] = cfg_reg.pix_out ? pix_out_req & ~PIXEL_OUT_PORT_GRANT_N
			: strobe[CPF_Q_RAW_OUT] & q_valid[CPF_Q_RAW_OUT];
	end
	for (genvar g = 0; g < 4; g++) begin : gen_q
		cpf_queue u_queue (
			.clk(REF_CLK),
			.rst_n(NRST),
			.push(q_push[g]),
			.din(q_din[g]),
			.full(q_full[g]),
			.pop(q_pop[g]),
			.dout(q_dout[g]),
			.valid(q_valid[g]),
			.level(q_level[g])
		);
	end
	////////////////////////////////////////////////////////////////////////
	// data bus drive, full word per edge, one queue at a time
	always_comb begin
		DATA_OUT = 32'h0000_0000;
		if (~TRANSFER_GRANT_N[CPF_Q_PACKED_OUT] | ~grant_d_reg[CPF_Q_PACKED_OUT]) begin
			DATA_OUT = q_dout[CPF_Q_PACKED_OUT];
		end else if (~TRANSFER_GRANT_N[CPF_Q_RAW_OUT] | ~grant_d_reg[CPF_Q_RAW_OUT])
				begin
			DATA_OUT = q_dout[CPF_Q_RAW_OUT];
		end
	end
	assign DATA_OE = ~TRANSFER_GRANT_N[CPF_Q_PACKED_OUT]
		| ~grant_d_reg[CPF_Q_PACKED_OUT]
		| (~cfg_reg.pix_out & (~TRANSFER_GRANT_N[CPF_Q_RAW_OUT]
		| ~grant_d_reg[CPF_Q_RAW_OUT]));
	////////////////////////////////////////////////////////////////////////
	// threshold requests
	assign RAW_IN_REQUEST_N = ~(~cfg_reg.pix_in
		& (space(q_level[CPF_Q_RAW_IN]) >= in_thr_reg));
	assign PACKED_IN_REQUEST_N = ~(space(q_level[CPF_Q_PACKED_IN]) >= in_thr_reg);
	assign PACKED_OUT_REQUEST_N = ~(q_valid[CPF_Q_PACKED_OUT]
		& (q_level[CPF_Q_PACKED_OUT] >= out_thr_reg));
	assign RAW_OUT_REQUEST_N = ~(~cfg_reg.pix_out & q_valid[CPF_Q_RAW_OUT]
		& (q_level[CPF_Q_RAW_OUT] >= out_thr_reg));
	////////////////////////////////////////////////////////////////////////
	// engines, each stalls on empty input or full output
	cpf_byte_engine u_comp (
		.clk(REF_CLK),
		.rst_n(NRST),
		.in_valid(q_valid[CPF_Q_RAW_IN]),
		.in_data(q_dout[CPF_Q_RAW_IN]),
		.in_bytes(cfg_reg.pix_in ? CPF_BYTES_PIX : port_bytes),
		.in_pop(ce_pop),
		.bitrev(cfg_reg.bitrev & ~cfg_reg.pass),
		.out_bytes(port_bytes),
		.out_ready(~q_full[CPF_Q_PACKED_OUT]),
		.out_valid(ce_valid),
		.out_data(ce_word),
		.byte_step(ce_step)
	);
	cpf_byte_engine u_decomp (
		.clk(REF_CLK),
		.rst_n(NRST),
		.in_valid(q_valid[CPF_Q_PACKED_IN]),
		.in_data(q_dout[CPF_Q_PACKED_IN]),
		.in_bytes(port_bytes),
		.in_pop(de_pop),
		.bitrev(1'b0),
		.out_bytes(cfg_reg.pix_out ? CPF_BYTES_PIX : port_bytes),
		.out_ready(~q_full[CPF_Q_RAW_OUT]),
		.out_valid(de_valid),
		.out_data(de_word),
		.byte_step()
	);
	////////////////////////////////////////////////////////////////////////
	// scan line tracking on compressor bytes
	assign line_end = ({4'h0, line_pos_reg} + 16'h0001) >= {4'h0, line_len_reg};
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			line_pos_reg <= 12'h000;
		end else if (ce_step) begin
			line_pos_reg <= line_end ? 12'h000 : line_pos_reg + 12'h001;
		end
	end
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			lines_reg <= 16'h0000;
		end else if (ce_step & line_end) begin
			lines_reg <= lines_reg + 16'h0001;
		end
	end
endmodule

// ==== verif/cpf_datapath_monitor.sv ====
// concurrent checks on the ports of the codec port queue datapath
`timescale 1ns/10ps
module cpf_datapath_monitor (
	input logic REF_CLK,
	input logic NRST,
	input logic [4:0] AVS_ADDRESS,
	input logic AVS_READ,
	input logic AVS_WRITE,
	input logic [31:0] AVS_READDATA,
	input logic AVS_WAITREQUEST,
	input logic DATA_OE,
	input logic [3:0] TRANSFER_GRANT_N,
	input logic RAW_IN_REQUEST_N,
	input logic RAW_OUT_REQUEST_N,
	input logic PIXEL_IN_PORT_REQUEST_N,
	input logic PIXEL_OUT_PORT_REQUEST_N,
	input logic PIXEL_OUT_PORT_GRANT_N,
	input logic [7:0] PIXEL_BYTE_OUTPUT
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);
	////////////////////////////////////////////////////////////////////////
	// register bus
	AST_ONE_WAIT: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("wait lasted more than one cycle");
	AST_FIRST_WAIT: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
		else $error("no wait in first request cycle");
	AST_UNMAPPED: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 5'h10 |-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!AVS_READ |=> $stable(AVS_READDATA))
		else $error("read data changed without read");
	////////////////////////////////////////////////////////////////////////
	// data port and pixel ports
	AST_OE_OUT: assert property (!TRANSFER_GRANT_N[1] |-> DATA_OE)
		else $error("data bus not driven on packed out grant");
	AST_OE_IDLE: assert property (TRANSFER_GRANT_N[1] && TRANSFER_GRANT_N[3] && $past(TRANSFER_GRANT_N[1])
		&& $past(TRANSFER_GRANT_N[3]) |-> !DATA_OE)
		else $error("data bus driven without output grant");
	AST_PIXIN_EXCL: assert property (!PIXEL_IN_PORT_REQUEST_N |-> RAW_IN_REQUEST_N)
		else $error("both raw input sources requested");
	AST_PIXOUT_EXCL: assert property (!PIXEL_OUT_PORT_REQUEST_N |-> RAW_OUT_REQUEST_N)
		else $error("both raw output sinks requested");
	AST_PIX_HOLD: assert property (!PIXEL_OUT_PORT_REQUEST_N && PIXEL_OUT_PORT_GRANT_N
		|=> $stable(PIXEL_BYTE_OUTPUT))
		else $error("pixel byte changed without transfer");
	C_PIX_OUT: cover property (!PIXEL_OUT_PORT_REQUEST_N && !PIXEL_OUT_PORT_GRANT_N);
	C_CO_POP: cover property (!TRANSFER_GRANT_N[1] ##1 TRANSFER_GRANT_N[1]);
	C_RD: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule
bind cpf_datapath cpf_datapath_monitor u_mon (
	.REF_CLK(REF_CLK),
	.NRST(NRST),
	.AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE),
	.AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.DATA_OE(DATA_OE),
	.TRANSFER_GRANT_N(TRANSFER_GRANT_N),
	.RAW_IN_REQUEST_N(RAW_IN_REQUEST_N),
	.RAW_OUT_REQUEST_N(RAW_OUT_REQUEST_N),
	.PIXEL_IN_PORT_REQUEST_N(PIXEL_IN_PORT_REQUEST_N),
	.PIXEL_OUT_PORT_REQUEST_N(PIXEL_OUT_PORT_REQUEST_N),
	.PIXEL_OUT_PORT_GRANT_N(PIXEL_OUT_PORT_GRANT_N),
	.PIXEL_BYTE_OUTPUT(PIXEL_BYTE_OUTPUT)
);

// ==== verif/cpf_peer_model.sv ====
// pixel port peer: grants requests, feeds a byte count, stalls on command
`timescale 1ns/10ps
module cpf_peer_model (
	input logic clk,
	input logic rst_n,
	input logic slow,
	input logic [7:0] limit,
	input logic in_req_n,
	output logic in_grant_n,
	output logic [7:0] in_byte,
	input logic out_req_n,
	output logic out_grant_n
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	assign cnt_next = cnt_reg + 8'(!in_req_n && !in_grant_n);
	////////////////////////////////////////////////////////////////////////
	// grants answer requests, bytes move at each granted edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
			in_grant_n <= 1'b1;
			out_grant_n <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			in_grant_n <= in_req_n || slow || cnt_next >= limit;
			out_grant_n <= out_req_n || slow;
		end
	end
	// released lines show the inverse of the next byte
	assign in_byte = in_grant_n ? ~cnt_reg : cnt_reg;
endmodule

// ==== verif/tb.sv ====
// self-checking bench of the codec port queue datapath
`timescale 1ns/10ps
module tb;
	import cpf_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] addr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata, dout, din = 32'h0;
	logic waitreq, doe, sq = 1'b0;
	logic [3:0] gnt_n = 4'hF;
	logic ci_req_n, co_req_n, di_req_n, do_req_n;
	logic [7:0] pix_in, pix_out;
	logic pi_req_n, pi_gnt_n, po_req_n, po_gnt_n;
	logic slow = 1'b0;
	logic [7:0] limit = 8'h00;
	integer seed = 34266;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	logic [31:0] exp_rd[$], exp_co[$], exp_do[$];
	logic [31:0] msk = 32'hFFFFFFFF;
	// strobe qualifier active low when set (strobe condition 011)
	logic lo = 1'b0;
	logic [31:0] cfgs [5] = '{32'h270, 32'h210, 32'h211, 32'h20E, 32'h31E};
	always #50 clk = ~clk;
	cpf_datapath u_dut (.REF_CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
		.STROBE_QUAL(sq), .TRANSFER_GRANT_N(gnt_n), .RAW_IN_REQUEST_N(ci_req_n),
		.PACKED_OUT_REQUEST_N(co_req_n), .PACKED_IN_REQUEST_N(di_req_n),
		.RAW_OUT_REQUEST_N(do_req_n), .PIXEL_BYTE_INPUT(pix_in),
		.PIXEL_IN_PORT_REQUEST_N(pi_req_n), .PIXEL_IN_PORT_GRANT_N(pi_gnt_n),
		.PIXEL_BYTE_OUTPUT(pix_out), .PIXEL_OUT_PORT_REQUEST_N(po_req_n),
		.PIXEL_OUT_PORT_GRANT_N(po_gnt_n));
	cpf_peer_model u_peer (.clk(clk), .rst_n(nrst), .slow(slow), .limit(limit),
		.in_req_n(pi_req_n), .in_grant_n(pi_gnt_n), .in_byte(pix_in),
		.out_req_n(po_req_n), .out_grant_n(po_gnt_n));
	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] take(ref logic [31:0] q[$]);
		return q.size() > 0 ? q.pop_front() : 32'hXXXXXXXX;
	endfunction
	function automatic logic [31:0] xf(input logic [31:0] w, input logic sw, input logic br);
		logic [31:0] r;
		logic [31:0] o;
		r = sw ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
		o = r;
		for (int i = 0; i < 32; i++) begin
			if (br) o[i] = r[(i & 24) + 7 - (i & 7)];
		end
		return o;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		be <= b;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (waitreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rdq(input logic [4:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		bus(1'b0, a, 32'h0, 4'hF);
	endtask
	// one grant at a time, optional wait state with the strobe qualifier inactive
	task dma(input int q, input logic [31:0] d);
		logic ws;
		ws = 1'($random(seed));
		gnt_n[q] <= 1'b0;
		din <= d;
		sq <= !ws ^ lo;
		@(posedge clk);
		if (ws) begin
			sq <= !lo;
			@(posedge clk);
		end
		gnt_n <= 4'hF;
		sq <= lo;
		din <= ~d;
	endtask
	////////////////////////////////////////////////////////////////////////
	// result watcher and timeout
	always @(posedge clk) begin
		cycles++;
		slow <= 1'($random(seed));
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
		if (nrst) begin
			if (rd && !waitreq) check(rdata, take(exp_rd));
			if (!gnt_n[1] && (sq ^ lo)) check(dout & msk, take(exp_co));
			if (!gnt_n[3] && (sq ^ lo)) check(dout & msk, take(exp_do));
			if (!po_req_n && !po_gnt_n) check({24'h0, pix_out}, take(exp_do));
		end
	end
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		int nci;
		int ndi;
		logic [31:0] w;
		logic [31:0] c;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rdq(CPF_OFS_CONFIG, 32'(CPF_RST_DSC) << 8);
		rdq(CPF_OFS_THRESH, (32'(CPF_RST_OUT_THR) << CPF_POS_OUT_THR) | 32'(CPF_RST_IN_THR));
		rdq(CPF_OFS_LINE, 32'(CPF_RST_LINE));
		rdq(5'h14, 32'h0);
		bus(1'b1, CPF_OFS_LINE, 32'hFFF, 4'hF);
		rdq(CPF_OFS_LINE, 32'(CPF_MAX_LINE));
		bus(1'b1, CPF_OFS_LINE, 32'h100, 4'hF);
		bus(1'b1, CPF_OFS_LINE, 32'hFFF023, 4'h1);
		rdq(CPF_OFS_LINE, 32'h100);
		bus(1'b1, 5'h18, 32'hFFFFFFFF, 4'hF);
		rdq(5'h18, 32'h0);
		bus(1'b1, CPF_OFS_THRESH, 32'h0104, 4'hF);
		rdq(CPF_OFS_THRESH, 32'h0104);
		for (int ph = 0; ph < 5; ph++) begin
			c = cfgs[ph];
			lo = c[8];
			bus(1'b1, CPF_OFS_CONFIG, c, 4'hF);
			msk = c[0] ? 32'h0000FFFF : 32'hFFFFFFFF;
			nci = 0;
			ndi = 0;
			if (c[5]) begin
				for (int k = 0; k < 8; k++) begin
					exp_co.push_back({8'(4*k+3), 8'(4*k+2), 8'(4*k+1), 8'(4*k)});
				end
				limit <= 8'h20;
				nci = 8;
			end
			while (nci < 8 || ndi < 8 || exp_co.size() > 0 || exp_do.size() > 0) begin
				@(posedge clk);
				w = $random(seed);
				if (!co_req_n) begin
					dma(CPF_Q_PACKED_OUT, w);
				end else if (!do_req_n) begin
					dma(CPF_Q_RAW_OUT, w);
				end else if (ndi < 8 && !di_req_n) begin
					ndi++;
					for (int b = 0; b < 4; b++) begin
						if (c[6]) exp_do.push_back(32'(w[8*b +: 8]));
					end
					if (!c[6]) exp_do.push_back(xf(w, c[2] & !c[4], 1'b0) & msk);
					dma(CPF_Q_PACKED_IN, w);
				end else if (nci < 8 && !ci_req_n) begin
					nci++;
					exp_co.push_back(xf(w, c[1] & !c[4], c[3] & !c[4]) & msk);
					dma(CPF_Q_RAW_IN, w);
				end
			end
		end
		final_report();
	end
endmodule
